// File: lld_consts.svh
// Register offsets, field positions, reset values and timing counts of the lane deskew block
`ifndef LLD_CONSTS_SVH
`define LLD_CONSTS_SVH

// Register indices; byte address is four times the index
`define LLD_IDX_LANE0_DELAY   8'h22
`define LLD_IDX_LANE1_DELAY   8'h24
`define LLD_IDX_LANE2_DELAY   8'h26
`define LLD_IDX_LANE3_DELAY   8'h28
`define LLD_IDX_TOP_FLAG      8'h29
`define LLD_IDX_BOTTOM_FLAG   8'h2a
`define LLD_IDX_MODE          8'h2c
`define LLD_IDX_IRQ_MASK      8'h2d
`define LLD_IDX_IRQ_STATUS    8'h2e

// Field positions
`define LLD_SETTING_MSB       3
`define LLD_SETTING_LSB       0
`define LLD_STS_TOP_ERR       0
`define LLD_STS_BOTTOM_ERR    1

// Mode codes and reset values
`define LLD_MODE_LANE0_ALL    2'h2
`define LLD_DELAY_RST         16'h0000
`define LLD_MODE_RST          2'h0
`define LLD_MASK_RST          2'h0

// Delay line length in units of one core clock
`define LLD_DELAY_TAPS        16

`endif

// File: lld_pkg.sv
// Types shared by the lane deskew block
package lld_pkg;

  // One Avalon-MM request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } lld_av_req_t;

  // The two alignment readouts
  typedef struct packed {
    logic [3:0] top;
    logic [3:0] bottom;
  } lld_flags_t;

  // The four lane delay settings
  typedef logic [3:0][15:0] lld_settings_t;

endpackage

// File: lld_top.sv
// Four-lane deskew delay with Avalon-MM register access and alignment readouts
//
// Summary of operation
// - Lane 0 delayed by its programmed units
// - Lanes 1 to 3 use own settings
// - Mode 2 applies lane 0 setting everywhere
// - Top readout holds setting MSB per lane
// - Nonzero top readout flags increase-unit error
// - Bottom readout holds setting LSB per lane
// - Bottom readout not all ones flags error
// - Lane settings read/write, reset to zero
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "lld_consts.svh"

module lld_top
  import lld_pkg::*;
#(
  parameter int NUM_LANES  = 4,
  parameter int DELAY_TAPS = `LLD_DELAY_TAPS
) (
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RSTN_IN,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // Link side
  input  wire logic        LINK_CLK_IN,
  input  wire logic [3:0]  LANE_DATA_IN,
  output logic      [3:0]  LANE_DATA_OUT,
  // Interrupt
  output logic             IRQ_OUT
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (NUM_LANES != 4) begin : g_bad_lanes
    $error("lld_top serves exactly four lanes");
  end
  if (DELAY_TAPS != 16) begin : g_bad_taps
    $error("lld_top needs sixteen delay taps for a four-bit setting");
  end

  // ***************************************************************
  // Declarations
  // ***************************************************************
  lld_av_req_t   req;
  lld_settings_t lane_r;
  lld_flags_t    flags;
  logic [1:0]    mode_r;
  logic [1:0]    mask_r;
  logic [1:0]    status_r;
  logic [1:0]    status_nxt;
  logic          waitreq_r;
  logic [31:0]   readdata_r;
  logic [31:0]   rd_nxt;
  logic          wr_accept;
  logic          rd_accept;
  logic          irq_r;
  logic [3:0]    lane_s1_r;
  logic [3:0]    lane_s2_r;
  logic          lclk_s1_r;
  logic          lclk_s2_r;
  logic          lclk_prev_r;
  logic          link_rise;
  logic [15:0]   dl_r [4];
  logic [3:0]    eff [4];
  logic [3:0]    lane_out_r;
  logic          top_err_prev_r;
  logic          bot_err_prev_r;
  logic          top_err;
  logic          bot_err;

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Delay code carried by a lane setting
  function automatic logic [3:0] delay_code(input logic [15:0] s);
    delay_code = s[3:0];
  endfunction

  // Pick the tap for a delay: zero takes the fresh bit
  function automatic logic tap_pick(input logic [15:0] line, input logic fresh, input logic [3:0] d);
    logic r;
    r = fresh;
    if (d != 4'h0) begin
      r = line[d - 4'h1];
    end
    tap_pick = r;
  endfunction

  // Byte-lane merge of a 16-bit setting
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    merge16 = r;
  endfunction

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  // Gather the request into one carrier
  always_comb begin
    req.read       = AVS_READ_IN;
    req.write      = AVS_WRITE_IN;
    req.address    = AVS_ADDRESS_IN;
    req.writedata  = AVS_WRITEDATA_IN;
    req.byteenable = AVS_BYTEENABLE_IN;
  end

  // Request takes effect at the edge where waitrequest is low
  assign wr_accept = req.write && !waitreq_r;
  assign rd_accept = req.read && !waitreq_r;

  // Waitrequest drops for one cycle after a request is seen
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !((req.read || req.write) && waitreq_r);
    end
  end

  // Read decode; unmapped and misaligned addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (req.address[1:0] == 2'h0) begin
      case ({2'h0, req.address[7:2]})
        `LLD_IDX_LANE0_DELAY:  rd_nxt[15:0] = lane_r[0];
        `LLD_IDX_LANE1_DELAY:  rd_nxt[15:0] = lane_r[1];
        `LLD_IDX_LANE2_DELAY:  rd_nxt[15:0] = lane_r[2];
        `LLD_IDX_LANE3_DELAY:  rd_nxt[15:0] = lane_r[3];
        `LLD_IDX_TOP_FLAG:     rd_nxt[3:0]  = flags.top;
        `LLD_IDX_BOTTOM_FLAG:  rd_nxt[3:0]  = flags.bottom;
        `LLD_IDX_MODE:         rd_nxt[1:0]  = mode_r;
        `LLD_IDX_IRQ_MASK:     rd_nxt[1:0]  = mask_r;
        `LLD_IDX_IRQ_STATUS:   rd_nxt[1:0]  = status_r;
        default:               rd_nxt       = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands from the answering edge
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      readdata_r <= 32'h0000_0000;
    end else if (req.read && waitreq_r) begin
      readdata_r <= rd_nxt;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // settings writable, zero at reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 4; i++) begin
        lane_r[i] <= `LLD_DELAY_RST;
      end
    end else if (wr_accept && req.address[1:0] == 2'h0) begin
      case ({2'h0, req.address[7:2]})
        `LLD_IDX_LANE0_DELAY: lane_r[0] <= merge16(lane_r[0], req.writedata, req.byteenable);
        `LLD_IDX_LANE1_DELAY: lane_r[1] <= merge16(lane_r[1], req.writedata, req.byteenable);
        `LLD_IDX_LANE2_DELAY: lane_r[2] <= merge16(lane_r[2], req.writedata, req.byteenable);
        `LLD_IDX_LANE3_DELAY: lane_r[3] <= merge16(lane_r[3], req.writedata, req.byteenable);
        default: ;
      endcase
    end
  end

  // Mode and interrupt mask
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      mode_r <= `LLD_MODE_RST;
      mask_r <= `LLD_MASK_RST;
    end else if (wr_accept && req.byteenable[0] && req.address[1:0] == 2'h0) begin
      if ({2'h0, req.address[7:2]} == `LLD_IDX_MODE) begin
        mode_r <= req.writedata[1:0];
      end
      if ({2'h0, req.address[7:2]} == `LLD_IDX_IRQ_MASK) begin
        mask_r <= req.writedata[1:0];
      end
    end
  end

  // ***************************************************************
  // Alignment readouts
  // ***************************************************************
  // flags straight from settings
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      flags.top[i]    = lane_r[i][`LLD_SETTING_MSB];
      flags.bottom[i] = lane_r[i][`LLD_SETTING_LSB];
    end
  end

  assign top_err = |flags.top;
  assign bot_err = ~&flags.bottom;

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  // Sticky status: clears only the bits the read returned, a new error wins
  always_comb begin
    status_nxt = status_r;
    if (rd_accept && {2'h0, req.address} == {`LLD_IDX_IRQ_STATUS, 2'h0}) begin
      status_nxt = status_r & ~readdata_r[1:0];
    end
    if (top_err && !top_err_prev_r) begin
      status_nxt[`LLD_STS_TOP_ERR] = 1'b1;
    end
    if (bot_err && !bot_err_prev_r) begin
      status_nxt[`LLD_STS_BOTTOM_ERR] = 1'b1;
    end
  end

  // Status, error history and interrupt line
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      status_r       <= 2'h0;
      top_err_prev_r <= 1'b0;
      bot_err_prev_r <= 1'b0;
      irq_r          <= 1'b0;
    end else begin
      status_r       <= status_nxt;
      top_err_prev_r <= top_err;
      bot_err_prev_r <= bot_err;
      irq_r          <= |(status_nxt & mask_r);
    end
  end

  // ***************************************************************
  // Link input sampling
  // ***************************************************************
  // Two-stage synchronisers for link clock and lanes
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      lclk_s1_r   <= 1'b0;
      lclk_s2_r   <= 1'b0;
      lclk_prev_r <= 1'b0;
      lane_s1_r   <= 4'h0;
      lane_s2_r   <= 4'h0;
    end else begin
      lclk_s1_r   <= LINK_CLK_IN;
      lclk_s2_r   <= lclk_s1_r;
      lclk_prev_r <= lclk_s2_r;
      lane_s1_r   <= LANE_DATA_IN;
      lane_s2_r   <= lane_s1_r;
    end
  end

  assign link_rise = lclk_s2_r && !lclk_prev_r;

  // ***************************************************************
  // Delay lines
  // ***************************************************************
  // One unit is one core clock
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 4; i++) begin
        dl_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        dl_r[i] <= {dl_r[i][14:0], lane_s2_r[i]};
      end
    end
  end

  // per-lane delay or lane 0 override
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eff[i] = (mode_r == `LLD_MODE_LANE0_ALL) ? delay_code(lane_r[0]) : delay_code(lane_r[i]);
    end
  end

  // delayed lanes captured on link clock rise
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      lane_out_r <= 4'h0;
    end else if (link_rise) begin
      for (int i = 0; i < 4; i++) begin
        lane_out_r[i] <= tap_pick(dl_r[i], lane_s2_r[i], eff[i]);
      end
    end
  end

  // Outputs
  assign AVS_READDATA_OUT    = readdata_r;
  assign AVS_WAITREQUEST_OUT = waitreq_r;
  assign LANE_DATA_OUT       = lane_out_r;
  assign IRQ_OUT             = irq_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  // Zero delay on lane 0 passes the fresh bit
  AST_LANE0_ZERO: assert property (link_rise && eff[0] == 4'h0 |=> lane_out_r[0] == $past(lane_s2_r[0]))
    else $error("lane 0 zero delay wrong");
  // Full delay on lane 0 is fifteen units
  AST_LANE0_FULL: assert property (link_rise && eff[0] == 4'hf |=> lane_out_r[0] == $past(lane_s2_r[0], 16))
    else $error("lane 0 fifteen unit delay wrong");
  // Lane 1 follows its own two-unit setting
  AST_LANE1_OWN: assert property (link_rise && mode_r != `LLD_MODE_LANE0_ALL && delay_code(lane_r[1]) == 4'h2
    |=> lane_out_r[1] == $past(lane_s2_r[1], 3))
    else $error("lane 1 delay wrong");
  // Mode 2 makes lane 3 follow the lane 0 setting
  AST_MODE_OVERRIDE: assert property (link_rise && mode_r == `LLD_MODE_LANE0_ALL && delay_code(lane_r[0]) == 4'h0
    |=> lane_out_r[3] == $past(lane_s2_r[3]))
    else $error("mode 2 override wrong");
  // Top readout answers with the setting MSBs
  AST_TOP_READ: assert property (rd_accept && {2'h0, req.address} == {`LLD_IDX_TOP_FLAG, 2'h0}
    |-> readdata_r == {28'h0, lane_r[3][3], lane_r[2][3], lane_r[1][3], lane_r[0][3]})
    else $error("top readout wrong");
  // Top error raises its sticky bit
  AST_TOP_STICKY: assert property ($rose(top_err) |=> status_r[`LLD_STS_TOP_ERR])
    else $error("top error not flagged");
  // Bottom readout answers with the setting LSBs
  AST_BOTTOM_READ: assert property (rd_accept && {2'h0, req.address} == {`LLD_IDX_BOTTOM_FLAG, 2'h0}
    |-> readdata_r == {28'h0, lane_r[3][0], lane_r[2][0], lane_r[1][0], lane_r[0][0]})
    else $error("bottom readout wrong");
  // Bottom error raises its sticky bit
  AST_BOTTOM_STICKY: assert property ($rose(bot_err) |=> status_r[`LLD_STS_BOTTOM_ERR])
    else $error("bottom error not flagged");
  // Settings are zero after reset
  AST_RESET_ZERO: assert property (@(posedge CORE_CLK_IN) disable iff (1'b0)
    !RSTN_IN |=> lane_r == '0 && mode_r == `LLD_MODE_RST)
    else $error("settings not zero after reset");
  // Lane 0 write shows in the top flag the next cycle
  AST_FLAG_NOW: assert property (wr_accept && {2'h0, req.address} == {`LLD_IDX_LANE0_DELAY, 2'h0} && req.byteenable[0]
    |=> flags.top[0] == $past(req.writedata[3]))
    else $error("top flag stale after write");
  // Every request is answered within two cycles
  AST_BUS_ANSWER: assert property ($rose(req.read || req.write) && waitreq_r |-> ##[0:2] !waitreq_r)
    else $error("bus request not answered");

  // Main scenarios
  COV_OVERRIDE: cover property (link_rise && mode_r == `LLD_MODE_LANE0_ALL);
  COV_TOP_ERR: cover property ($rose(top_err));
  COV_ALIGNED: cover property (!top_err && !bot_err);
  COV_IRQ: cover property ($rose(irq_r));

endmodule

// File: lld_src_model.sv
// Behavioural video source that drives the link clock and the four lanes
`timescale 1ns/1ps
module lld_src_model (
  // Frame control from the bench
  input  wire logic       run_in,
  input  wire logic [3:0] val_in,
  // Link pins
  output logic            link_clk_out,
  output logic [3:0]      lane_out
);
  // ************************************************************
  // Link clock and lane bits
  // ************************************************************
  // Idle levels before the first frame
  initial begin
    link_clk_out = 1'b0;
    lane_out     = 4'h0;
  end

  // Clock stands still low between frames; lanes change on the falling edge
  always begin
    if (run_in === 1'b1) begin
      #62.5 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
      lane_out = val_in;
    end else begin
      @(posedge run_in);
    end
  end
endmodule

// File: lld_top_bench.sv
// Self-checking bench for the lane deskew block
`timescale 1ns/1ps
`include "lld_consts.svh"
module lld_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        link_clk;
  logic [3:0]  lane_in;
  logic [3:0]  lane_out;
  logic        irq;
  logic        src_run = 1'b0;
  logic [3:0]  src_val = 4'h0;
  logic [31:0] q;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          idx [4];

  // ************************************************************
  // Clock, instances and hang guard
  // ************************************************************
  // Core clock of 10 ns
  always #5 clk = ~clk;

  lld_top i_lld_top (
    .CORE_CLK_IN         (clk),
    .RSTN_IN             (rst_n),
    .AVS_ADDRESS_IN      (addr),
    .AVS_READ_IN         (rd),
    .AVS_WRITE_IN        (wr),
    .AVS_WRITEDATA_IN    (wdata),
    .AVS_BYTEENABLE_IN   (4'hf),
    .AVS_READDATA_OUT    (rdata),
    .AVS_WAITREQUEST_OUT (waitreq),
    .LINK_CLK_IN         (link_clk),
    .LANE_DATA_IN        (lane_in),
    .LANE_DATA_OUT       (lane_out),
    .IRQ_OUT             (irq)
  );

  lld_src_model i_lld_src_model (
    .run_in       (src_run),
    .val_in       (src_val),
    .link_clk_out (link_clk),
    .lane_out     (lane_in)
  );

  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  // Verdict and end of run
  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] ri, input logic [31:0] d);
    addr  <= {ri[5:0], 2'b00};
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    // Waitrequest is low for one cycle only
    check("waitrequest", {31'h0, waitreq}, 32'h1);
  endtask

  // Read a register and compare it
  task automatic rchk(input string name, input logic [7:0] ri, input logic [31:0] exp);
    bus(1'b0, ri, 32'h0);
    check(name, q, exp);
  endtask

  // Write all four lane settings
  task automatic lanes(input logic [15:0] a, b, c, d);
    bus(1'b1, `LLD_IDX_LANE0_DELAY, {16'h0, a});
    bus(1'b1, `LLD_IDX_LANE1_DELAY, {16'h0, b});
    bus(1'b1, `LLD_IDX_LANE2_DELAY, {16'h0, c});
    bus(1'b1, `LLD_IDX_LANE3_DELAY, {16'h0, d});
  endtask

  // Step all lanes together and note the link rise at which each output turns
  task automatic measure();
    int k;
    idx = '{default: 0};
    src_val <= 4'h0;
    src_run <= 1'b1;
    repeat (6) @(posedge link_clk);
    @(posedge clk);
    src_val <= 4'hf;
    for (k = 1; k < 15; k++) begin
      @(posedge link_clk);
      for (int i = 0; i < 4; i++)
        if (idx[i] == 0 && lane_out[i] === 1'b1) idx[i] = k;
    end
    @(posedge clk);
    src_run <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values, unmapped place, reset-time status
  task automatic t_reset();
    rchk("lane0", `LLD_IDX_LANE0_DELAY, 32'h0);
    rchk("lane1", `LLD_IDX_LANE1_DELAY, 32'h0);
    rchk("lane2", `LLD_IDX_LANE2_DELAY, 32'h0);
    rchk("lane3", `LLD_IDX_LANE3_DELAY, 32'h0);
    rchk("top", `LLD_IDX_TOP_FLAG, 32'h0);
    rchk("bottom", `LLD_IDX_BOTTOM_FLAG, 32'h0);
    rchk("unmapped", 8'h23, 32'h0);
    rchk("status", `LLD_IDX_IRQ_STATUS, 32'h2);
    check("irq", {31'h0, irq}, 32'h0);
  endtask

  // Full-width read back and readouts right after writes
  task automatic t_regs();
    lanes(16'h5a08, 16'h0001, 16'hc009, 16'h0000);
    rchk("top", `LLD_IDX_TOP_FLAG, 32'h5);
    rchk("bottom", `LLD_IDX_BOTTOM_FLAG, 32'h6);
    rchk("lane0", `LLD_IDX_LANE0_DELAY, 32'h5a08);
    rchk("lane2", `LLD_IDX_LANE2_DELAY, 32'hc009);
    bus(1'b1, `LLD_IDX_TOP_FLAG, 32'h0);
    bus(1'b1, 8'h23, 32'hffff);
    rchk("top_ro", `LLD_IDX_TOP_FLAG, 32'h5);
    rchk("unmapped", 8'h23, 32'h0);
  endtask

  // Error events raise, mask and clear the interrupt
  task automatic t_irq();
    bus(1'b1, `LLD_IDX_IRQ_MASK, 32'h3);
    repeat (3) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    rchk("status", `LLD_IDX_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    lanes(16'h0001, 16'h0001, 16'h0001, 16'h0001);
    rchk("bottom", `LLD_IDX_BOTTOM_FLAG, 32'hf);
    rchk("status", `LLD_IDX_IRQ_STATUS, 32'h0);
    bus(1'b1, `LLD_IDX_IRQ_MASK, 32'h1);
    bus(1'b1, `LLD_IDX_LANE0_DELAY, 32'h0);
    repeat (3) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    rchk("status", `LLD_IDX_IRQ_STATUS, 32'h2);
    rchk("mask", `LLD_IDX_IRQ_MASK, 32'h1);
  endtask

  // Each lane follows its own delay setting
  task automatic t_delay();
    bus(1'b1, `LLD_IDX_MODE, 32'h0);
    lanes(16'h0000, 16'hffff, 16'h0000, 16'h000f);
    measure();
    check("late1", {31'h0, idx[1] > idx[0]}, 32'h1);
    check("same2", {31'h0, idx[2] == idx[0] && idx[0] != 0}, 32'h1);
    check("same3", {31'h0, idx[3] == idx[1]}, 32'h1);
    lanes(16'hffff, 16'h0001, 16'h0000, 16'h000f);
    measure();
    check("late0a", {31'h0, idx[0] > idx[1]}, 32'h1);
    check("late0b", {31'h0, idx[0] > idx[2]}, 32'h1);
  endtask

  // Mode 2 puts the lane 0 setting on every lane
  task automatic t_mode();
    bus(1'b1, `LLD_IDX_MODE, 32'h2);
    rchk("mode", `LLD_IDX_MODE, 32'h2);
    measure();
    check("all1", {31'h0, idx[1] == idx[0] && idx[0] != 0}, 32'h1);
    check("all2", {31'h0, idx[2] == idx[0]}, 32'h1);
    rchk("lane1", `LLD_IDX_LANE1_DELAY, 32'h1);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_irq();
    t_delay();
    t_mode();
    results();
  end
endmodule
